/* hw/ptq_pkg.sv */
// Constants, encodings and helpers for the transmit queue framing control block
package ptq_pkg;
  localparam logic [11:0] A_CTRL_A = 12'h000;
  localparam logic [11:0] A_CTRL_B = 12'h004;
  localparam logic [11:0] A_BYTE_COUNT = 12'h008;
  localparam logic [11:0] A_SW_ABORT = 12'h00c;
  localparam logic [11:0] A_AUTO_ABORT = 12'h010;
  localparam logic [11:0] A_QUEUE_BASE = 12'h100;
  localparam logic [11:0] A_QUEUE_END = 12'h228;
  localparam logic [6:0] QUEUE_DEPTH = 7'h4a;
  localparam logic [6:0] QUEUE_LAST = 7'h49;
  localparam int CA_RAW = 0;
  localparam int CA_FIFO = 1;
  localparam int CA_QUIET = 2;
  localparam int CA_SR_OFF = 3;
  localparam int CA_CROSS_OFF = 4;
  localparam int CA_CABLE_EN = 5;
  localparam int CB_GO = 0;
  localparam int CB_PTR_CLR = 1;
  localparam int CB_ABORT = 2;
  localparam int CB_PERMIT = 3;
  localparam int CB_SOP_LSB = 4;
  localparam int CB_RESET_KIND = 7;
  localparam int AB_SOFTWARE = 0;
  localparam int AB_RX = 1;
  localparam int AB_BUSY = 2;
  localparam int AB_DONE = 3;
  localparam logic [5:0] CTRL_A_RESET = 6'h00;
  localparam logic [6:0] BYTE_COUNT_RESET = 7'h00;
  localparam logic [2:0] SOP_PRIMARY = 3'h0;
  localparam logic [4:0] SYM_SYNC1 = 5'h18;
  localparam logic [4:0] SYM_SYNC2 = 5'h11;
  localparam logic [4:0] SYM_EOP = 5'h0d;
  localparam logic [7:0] CODE_CRC = 8'hff;
  localparam logic [7:0] CODE_STOP = 8'hfe;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY_REFL = 32'hedb88320;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TURNAROUND_NS = 1000;
  localparam int POWERUP_NS = 1000;
  localparam logic [7:0] TA_CYCLES = 8'((TURNAROUND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PU_CYCLES = 8'((POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] SRC_SR_ACK = 2'h0;
  localparam logic [1:0] SRC_ACK = 2'h1;
  localparam logic [1:0] SRC_BIST = 2'h2;
  localparam logic [1:0] SRC_SW = 2'h3;

  typedef enum logic [3:0] {
    S_IDLE, S_WAIT_TIMERS, S_WAIT_IDLE, S_TA_AGAIN, S_AUTO_RSP, S_SOP, S_DATA, S_CRC, S_EOP, S_DONE
  } ptq_state_e;

  function automatic logic [4:0] ptq_enc(input logic [3:0] nib);
    logic [4:0] sym;
    sym = 5'h00;
    unique case (nib)
      4'h0: sym = 5'h1e;
      4'h1: sym = 5'h09;
      4'h2: sym = 5'h14;
      4'h3: sym = 5'h15;
      4'h4: sym = 5'h0a;
      4'h5: sym = 5'h0b;
      4'h6: sym = 5'h0e;
      4'h7: sym = 5'h0f;
      4'h8: sym = 5'h12;
      4'h9: sym = 5'h13;
      4'ha: sym = 5'h16;
      4'hb: sym = 5'h17;
      4'hc: sym = 5'h1a;
      4'hd: sym = 5'h1b;
      4'he: sym = 5'h1c;
      4'hf: sym = 5'h1d;
    endcase
    return sym;
  endfunction : ptq_enc

  // Reflected CRC32, one nibble, least significant bit first
  function automatic logic [31:0] ptq_crc_nib(input logic [31:0] crc, input logic [3:0] nib);
    logic [31:0] c;
    c = crc ^ {28'h0000000, nib};
    for (int i = 0; i < 4; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction : ptq_crc_nib
endpackage : ptq_pkg

/* hw/ptq_tx_control.sv */
// Transmit queue, launch arbitration, abort handling and symbol framing
//
// Functional notes
// - Automatic mode: queue holds only header and data object bytes.
// - Automatic mode: byte count places the CRC; hardware adds SOP and EOP.
// - Raw byte with bit 5 clear: low nibble feeds CRC and gets encoded.
// - Raw byte with bit 5 set: low five bits sent as-is, no CRC.
// - Nibble to five-bit symbol uses the fixed sixteen-entry table.
// - Sync-1, Sync-2, EOP, RST1, RST2 queued as symbols with bit 5 set.
// - Byte ff ends data; accumulated CRC32 is then sent.
// - Byte fe stops the transmission at once.
// - Raw mode without stop code wraps the queue forever.
// - Raw mode ignores the byte count; only the stop code ends it.
// - Four request sources: soft-reset ack, ack, BIST count, software launch.
// - Launch powers analog, waits timers; software and received events may abort.
// - After timers: idle line starts, busy line discards unless kept.
// - Kept request waits idle then turn-around again, still abortable.
// - Software hard and cable resets ignore received-event aborts.
// - Good packet aborts only on SOP match or cross rule, non-duplicate or soft reset.
// - Ping and ack messages never abort.
// - Software and auto-response aborts report in separate status and flags.
// - Queue of 74 bytes, addressable buffer or write-only FIFO.
`timescale 1ns/100ps
module ptq_tx_control import ptq_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic req_sr_ack,
  input wire logic req_ack,
  input wire logic req_bist,
  input wire logic [2:0] auto_sop,
  input wire logic auto_done,
  input wire logic rx_busy,
  input wire logic line_idle,
  input wire logic rx_good,
  input wire logic [2:0] rx_sop,
  input wire logic rx_soft_reset,
  input wire logic rx_ping_or_ack,
  input wire logic rx_duplicate,
  input wire logic rx_hard_reset,
  input wire logic rx_cable_reset,
  input wire logic sym_ready,
  output logic sym_valid,
  output logic [4:0] sym_data,
  output logic analog_pwr_en,
  output logic frame_start,
  output logic auto_start,
  output logic sw_abort_flag,
  output logic auto_abort_flag
);
  logic [7:0] mem [0:73];
  ptq_state_e st, next_st;
  logic [5:0] ctrl_a, next_ctrl_a;
  logic go, next_go, reset_kind, next_reset_kind, permit, next_permit;
  logic [2:0] sop_sel, next_sop_sel, pend_sop, next_pend_sop, pend, next_pend;
  logic [6:0] byte_count, next_byte_count, wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [6:0] bytes_left, next_bytes_left;
  logic [3:0] sw_ab, next_sw_ab, auto_ab, next_auto_ab;
  logic [1:0] src, next_src;
  logic [7:0] ta_cnt, next_ta_cnt, pu_cnt, next_pu_cnt;
  logic [31:0] crc, next_crc, next_rdata;
  logic [3:0] idx, next_idx;
  logic nib_hi, next_nib_hi;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic next_sym_valid, next_analog, next_frame_start, next_auto_start;
  logic [4:0] next_sym_data;
  logic mem_we;
  logic [6:0] mem_wa;
  logic wr_fire, rd_fire, wq_hit, rq_hit, sw_abort_w, slot, rx_abort, keep, waiting;
  logic [6:0] wq_idx, rq_idx;
  logic [11:0] wq_off, rq_off;
  logic [7:0] cur_byte;
  logic [3:0] cur_nib;

  assign wr_fire = awready && awvalid && wvalid;
  assign rd_fire = arready && arvalid;
  assign wq_off = awaddr - A_QUEUE_BASE;
  assign rq_off = araddr - A_QUEUE_BASE;
  assign wq_hit = awaddr >= A_QUEUE_BASE && awaddr < A_QUEUE_END && awaddr[1:0] == 2'h0;
  assign rq_hit = araddr >= A_QUEUE_BASE && araddr < A_QUEUE_END && araddr[1:0] == 2'h0;
  assign wq_idx = wq_off[8:2];
  assign rq_idx = rq_off[8:2];
  assign sw_abort_w = wr_fire && wstrb[0] && awaddr == A_CTRL_B && wdata[CB_ABORT];
  assign slot = !sym_valid || sym_ready;
  assign cur_byte = mem[rd_ptr];
  assign cur_nib = nib_hi ? cur_byte[7:4] : cur_byte[3:0];
  assign waiting = st == S_WAIT_TIMERS || st == S_WAIT_IDLE || st == S_TA_AGAIN;
  // Busy line keeps the request instead of discarding it
  assign keep = ctrl_a[CA_QUIET] || (src == SRC_SR_ACK && !ctrl_a[CA_SR_OFF]);
  always_comb begin
    rx_abort = rx_hard_reset || (rx_cable_reset && ctrl_a[CA_CABLE_EN] && pend_sop != SOP_PRIMARY);
    if (rx_good && !rx_ping_or_ack && (rx_soft_reset || !rx_duplicate) && (rx_sop == pend_sop ||
        (rx_sop == SOP_PRIMARY && pend_sop != SOP_PRIMARY && !ctrl_a[CA_CROSS_OFF]))) begin
      rx_abort = 1'b1;
    end
    if (src == SRC_SW && reset_kind) begin
      rx_abort = 1'b0;
    end
  end

  always_comb begin
    next_awready = awvalid && wvalid && !awready && !bvalid;
    next_wready = awvalid && wvalid && !awready && !bvalid;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_arready = arvalid && !arready && !rvalid;
    next_rvalid = rvalid && !rready;
    next_rresp = rresp;
    next_rdata = rdata;
    next_ctrl_a = ctrl_a;
    next_go = go;
    next_sop_sel = sop_sel;
    next_reset_kind = reset_kind;
    next_byte_count = byte_count;
    next_wr_ptr = wr_ptr;
    next_sw_ab = sw_ab;
    next_auto_ab = auto_ab;
    next_pend = pend;
    next_permit = !go && !rx_busy && line_idle;
    mem_we = 1'b0;
    mem_wa = wq_idx;
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (!wstrb[0]) begin
        next_bresp = RESP_OKAY;
      end else if (awaddr == A_CTRL_A) begin
        next_ctrl_a = wdata[5:0];
      end else if (awaddr == A_CTRL_B) begin
        if (!go) begin
          next_go = wdata[CB_GO];
          next_sop_sel = wdata[CB_SOP_LSB +: 3];
          next_reset_kind = wdata[CB_RESET_KIND];
        end
        if (wdata[CB_PTR_CLR]) begin
          next_wr_ptr = 7'h00;
        end
      end else if (awaddr == A_BYTE_COUNT) begin
        next_byte_count = wdata[6:0];
      end else if (awaddr == A_SW_ABORT) begin
        next_sw_ab = sw_ab & ~wdata[3:0];
      end else if (awaddr == A_AUTO_ABORT) begin
        next_auto_ab = auto_ab & ~wdata[3:0];
      end else if (wq_hit) begin
        // FIFO mode ignores the offset; writes past the last entry are dropped
        if (ctrl_a[CA_FIFO]) begin
          mem_we = wr_ptr < QUEUE_DEPTH;
          mem_wa = wr_ptr;
          next_wr_ptr = (wr_ptr < QUEUE_DEPTH) ? wr_ptr + 7'h01 : wr_ptr;
        end else begin
          mem_we = 1'b1;
        end
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h00000000;
      if (araddr == A_CTRL_A) begin
        next_rdata[5:0] = ctrl_a;
      end else if (araddr == A_CTRL_B) begin
        next_rdata[7:0] = {reset_kind, sop_sel, permit, 2'h0, go};
      end else if (araddr == A_BYTE_COUNT) begin
        next_rdata[6:0] = byte_count;
      end else if (araddr == A_SW_ABORT) begin
        next_rdata[3:0] = sw_ab;
      end else if (araddr == A_AUTO_ABORT) begin
        next_rdata[3:0] = auto_ab;
      end else if (rq_hit) begin
        next_rdata[7:0] = ctrl_a[CA_FIFO] ? 8'h00 : mem[rq_idx];
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
    // Requests held until taken; a new one outranks the clear
    next_pend = {pend[2] | req_bist, pend[1] | req_ack, pend[0] | req_sr_ack};
    next_st = st;
    next_src = src;
    next_pend_sop = pend_sop;
    next_ta_cnt = (ta_cnt != 8'h00) ? ta_cnt - 8'h01 : ta_cnt;
    next_pu_cnt = (pu_cnt != 8'h00) ? pu_cnt - 8'h01 : pu_cnt;
    next_rd_ptr = rd_ptr;
    next_bytes_left = bytes_left;
    next_crc = crc;
    next_idx = idx;
    next_nib_hi = nib_hi;
    next_sym_valid = sym_valid && !sym_ready;
    next_sym_data = sym_data;
    next_analog = analog_pwr_en;
    next_frame_start = 1'b0;
    next_auto_start = 1'b0;
    unique case (st)
      S_IDLE: begin
        next_analog = 1'b0;
        if (pend != 3'h0 || go) begin
          next_st = S_WAIT_TIMERS;
          next_analog = 1'b1;
          next_ta_cnt = TA_CYCLES;
          next_pu_cnt = PU_CYCLES;
          next_pend_sop = auto_sop;
          if (pend[0]) begin
            next_src = SRC_SR_ACK;
            next_pend[0] = req_sr_ack;
          end else if (pend[1]) begin
            next_src = SRC_ACK;
            next_pend[1] = req_ack;
          end else if (pend[2]) begin
            next_src = SRC_BIST;
            next_pend[2] = req_bist;
          end else begin
            next_src = SRC_SW;
            next_pend_sop = sop_sel;
          end
        end
      end
      S_WAIT_TIMERS, S_WAIT_IDLE, S_TA_AGAIN: begin
        if (sw_abort_w || rx_abort) begin
          next_st = S_IDLE;
          if (src == SRC_SW) begin
            next_go = 1'b0;
            next_sw_ab[rx_abort ? AB_RX : AB_SOFTWARE] = 1'b1;
          end else begin
            next_auto_ab[rx_abort ? AB_RX : AB_SOFTWARE] = 1'b1;
          end
        end else if (st == S_WAIT_IDLE) begin
          if (line_idle) begin
            next_st = S_TA_AGAIN;
            next_ta_cnt = TA_CYCLES;
          end
        end else if (ta_cnt == 8'h00 && pu_cnt == 8'h00) begin
          if (line_idle) begin
            next_crc = CRC_INIT;
            next_idx = 4'h0;
            next_rd_ptr = 7'h00;
            next_nib_hi = 1'b0;
            next_bytes_left = byte_count;
            if (src == SRC_SW) begin
              next_frame_start = 1'b1;
              next_st = ctrl_a[CA_RAW] ? S_DATA : S_SOP;
            end else begin
              next_auto_start = 1'b1;
              next_st = S_AUTO_RSP;
            end
          end else if (keep) begin
            next_st = S_WAIT_IDLE;
          end else begin
            next_st = S_IDLE;
            if (src == SRC_SW) begin
              next_go = 1'b0;
              next_sw_ab[AB_BUSY] = 1'b1;
            end else begin
              next_auto_ab[AB_BUSY] = 1'b1;
            end
          end
        end
      end
      S_AUTO_RSP: begin
        if (auto_done) begin
          next_st = S_IDLE;
          next_auto_ab[AB_DONE] = 1'b1;
        end
      end
      S_SOP: begin
        if (slot) begin
          next_sym_valid = 1'b1;
          next_sym_data = (idx == 4'h3) ? SYM_SYNC2 : SYM_SYNC1;
          next_idx = idx + 4'h1;
          if (idx == 4'h3) begin
            next_idx = 4'h0;
            next_st = (byte_count == 7'h00) ? S_CRC : S_DATA;
          end
        end
      end
      S_DATA: begin
        if (slot && !ctrl_a[CA_RAW]) begin
          // Bytes only, low nibble first; count alone places the CRC
          next_sym_valid = 1'b1;
          next_sym_data = ptq_enc(cur_nib);
          next_crc = ptq_crc_nib(crc, cur_nib);
          next_nib_hi = !nib_hi;
          if (nib_hi) begin
            next_rd_ptr = rd_ptr + 7'h01;
            next_bytes_left = bytes_left - 7'h01;
            if (bytes_left == 7'h01) begin
              next_st = S_CRC;
            end
          end
        end else if (slot) begin
          // Only the stop code ends a raw frame, so the pointer wraps
          next_rd_ptr = (rd_ptr == QUEUE_LAST) ? 7'h00 : rd_ptr + 7'h01;
          if (cur_byte == CODE_STOP) begin
            next_st = S_DONE;
          end else if (cur_byte == CODE_CRC) begin
            next_st = S_CRC;
            next_idx = 4'h0;
          end else if (cur_byte[5]) begin
            next_sym_valid = 1'b1;
            next_sym_data = cur_byte[4:0];
          end else begin
            next_sym_valid = 1'b1;
            next_sym_data = ptq_enc(cur_byte[3:0]);
            next_crc = ptq_crc_nib(crc, cur_byte[3:0]);
          end
        end
      end
      S_CRC: begin
        if (slot) begin
          next_sym_valid = 1'b1;
          next_sym_data = ptq_enc(4'(~crc >> {idx[2:0], 2'h0}));
          next_idx = idx + 4'h1;
          if (idx == 4'h7) begin
            next_idx = 4'h0;
            next_st = ctrl_a[CA_RAW] ? S_DATA : S_EOP;
          end
        end
      end
      S_EOP: begin
        if (slot) begin
          next_sym_valid = 1'b1;
          next_sym_data = SYM_EOP;
          next_st = S_DONE;
        end
      end
      S_DONE: begin
        if (slot) begin
          next_st = S_IDLE;
          next_go = 1'b0;
          next_sw_ab[AB_DONE] = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_wa] <= wdata[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= S_IDLE;
      ctrl_a <= CTRL_A_RESET;
      go <= 1'b0;
      sop_sel <= SOP_PRIMARY;
      reset_kind <= 1'b0;
      permit <= 1'b0;
      byte_count <= BYTE_COUNT_RESET;
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      bytes_left <= 7'h00;
      sw_ab <= 4'h0;
      auto_ab <= 4'h0;
      pend <= 3'h0;
      src <= SRC_SW;
      pend_sop <= SOP_PRIMARY;
      ta_cnt <= 8'h00;
      pu_cnt <= 8'h00;
      crc <= CRC_INIT;
      idx <= 4'h0;
      nib_hi <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h00000000;
      sym_valid <= 1'b0;
      sym_data <= 5'h00;
      analog_pwr_en <= 1'b0;
      frame_start <= 1'b0;
      auto_start <= 1'b0;
      sw_abort_flag <= 1'b0;
      auto_abort_flag <= 1'b0;
    end else begin
      st <= next_st;
      ctrl_a <= next_ctrl_a;
      go <= next_go;
      sop_sel <= next_sop_sel;
      reset_kind <= next_reset_kind;
      permit <= next_permit;
      byte_count <= next_byte_count;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      bytes_left <= next_bytes_left;
      sw_ab <= next_sw_ab;
      auto_ab <= next_auto_ab;
      pend <= next_pend;
      src <= next_src;
      pend_sop <= next_pend_sop;
      ta_cnt <= next_ta_cnt;
      pu_cnt <= next_pu_cnt;
      crc <= next_crc;
      idx <= next_idx;
      nib_hi <= next_nib_hi;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      sym_valid <= next_sym_valid;
      sym_data <= next_sym_data;
      analog_pwr_en <= next_analog;
      frame_start <= next_frame_start;
      auto_start <= next_auto_start;
      sw_abort_flag <= |next_sw_ab[2:0];
      auto_abort_flag <= |next_auto_ab[2:0];
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ENC_TABLE: assert property ((st == S_DATA && !ctrl_a[CA_RAW] && slot)
    |=> sym_valid && sym_data == ptq_enc($past(cur_nib))) else $error("Nibble encoding wrong");
  AST_RAW_KCODE: assert property ((st == S_DATA && ctrl_a[CA_RAW] && slot && cur_byte[7:6] != 2'h3 && cur_byte[5])
    |=> sym_data == $past(cur_byte[4:0]) && crc == $past(crc)) else $error("Raw symbol altered");
  AST_RAW_DATA_CRC: assert property ((st == S_DATA && ctrl_a[CA_RAW] && slot && !cur_byte[5])
    |=> crc == ptq_crc_nib($past(crc), $past(cur_byte[3:0]))) else $error("Raw nibble missed CRC");
  AST_STOP_CODE: assert property ((st == S_DATA && ctrl_a[CA_RAW] && slot && cur_byte == CODE_STOP)
    |=> st == S_DONE ##1 st == S_IDLE || sym_valid) else $error("Stop code not honoured");
  AST_CRC_CODE: assert property ((st == S_DATA && ctrl_a[CA_RAW] && slot && cur_byte == CODE_CRC)
    |=> st == S_CRC && idx == 4'h0) else $error("CRC code not honoured");
  AST_AUTO_LEN: assert property ((st == S_DATA && !ctrl_a[CA_RAW] && slot && nib_hi && bytes_left == 7'h01)
    |=> st == S_CRC [*1] ##[1:16] st == S_EOP) else $error("CRC not placed by count");
  AST_RAW_WRAP: assert property ((st == S_DATA && ctrl_a[CA_RAW] && slot && rd_ptr == QUEUE_LAST)
    |=> rd_ptr == 7'h00) else $error("Raw pointer did not wrap");
  AST_GO_CLEAR: assert property ((st == S_DONE && slot && src == SRC_SW)
    |=> !go && st == S_IDLE) else $error("Launch bit not cleared");
  AST_RESET_KEEP: assert property ((waiting && (line_idle || st == S_WAIT_IDLE) && reset_kind
    && src == SRC_SW && !sw_abort_w) |=> st != S_IDLE) else $error("Software reset aborted by receive");
  AST_PING_KEEP: assert property ((st == S_WAIT_IDLE && rx_good && rx_ping_or_ack && !rx_hard_reset
    && !rx_cable_reset && !sw_abort_w) |=> st != S_IDLE) else $error("Ping or ack aborted");
  AST_BUSY_DISCARD: assert property ((st == S_WAIT_TIMERS && ta_cnt == 8'h00 && pu_cnt == 8'h00 && !line_idle
    && !keep && !sw_abort_w && !rx_abort) |=> st == S_IDLE && (sw_ab[AB_BUSY] || auto_ab[AB_BUSY]))
    else $error("Busy line not discarded");

  COV_AUTO_FRAME: cover property (st == S_SOP ##[1:300] st == S_EOP);
  COV_RAW_STOP: cover property (st == S_DATA && ctrl_a[CA_RAW] && cur_byte == CODE_STOP && slot);
  COV_RX_ABORT: cover property (waiting && rx_abort);
  COV_KEEP_WAIT: cover property (st == S_WAIT_IDLE ##[1:100] st == S_TA_AGAIN);
endmodule : ptq_tx_control

/* dv/ptq_sym_sink.sv */
// Symbol sink model that stalls and records taken symbols
`timescale 1ns/100ps
module ptq_sym_sink (
  input wire logic aclk,
  input wire logic sym_valid,
  input wire logic [4:0] sym_data,
  output logic sym_ready
);
  logic [4:0] got[$];
  logic phase = 1'b0;
  assign sym_ready = phase;
  // Stall every other cycle so each symbol must hold
  always @(posedge aclk) begin
    if (sym_valid && sym_ready) got.push_back(sym_data);
    phase <= !phase;
  end
endmodule : ptq_sym_sink

/* dv/tb.sv */
// Self-checking bench for the transmit framing control block
`timescale 1ns/100ps
module tb import ptq_pkg::*;;
  logic aclk, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
  logic awready, wready, bvalid, arready, rvalid, sym_ready, sym_valid, analog_pwr_en;
  logic frame_start, auto_start, sw_abort_flag, auto_abort_flag;
  logic req_sr_ack = 0, req_ack = 0, req_bist = 0, auto_done = 0, rx_busy = 0, line_idle = 1;
  logic rx_good = 0, rx_soft_reset = 0, rx_ping_or_ack = 0, rx_duplicate = 0, rx_hard_reset = 0, rx_cable_reset = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, r;
  logic [2:0] auto_sop = 0, rx_sop = 0;
  logic [4:0] sym_data;
  int errors = 0, total_checks = 0;
  ptq_tx_control dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .req_sr_ack,
    .req_ack, .req_bist, .auto_sop, .auto_done, .rx_busy, .line_idle, .rx_good, .rx_sop, .rx_soft_reset,
    .rx_ping_or_ack, .rx_duplicate, .rx_hard_reset, .rx_cable_reset, .sym_ready, .sym_valid, .sym_data,
    .analog_pwr_en, .frame_start, .auto_start, .sw_abort_flag, .auto_abort_flag);
  ptq_sym_sink sink (.aclk, .sym_valid, .sym_data, .sym_ready);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask : wr
  task rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
  endtask : rd
  // Launch bit falls when the request ends, done or not
  task wait_go;
    do rd(A_CTRL_B); while (d[CB_GO] !== 1'b0);
  endtask : wait_go
  task t_raw;
    logic [7:0] q[23] = '{8'h38, 8'h31, 8'h27, 8'h39, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'hff, 8'h2d, 8'hfe};
    logic [4:0] e[20] = '{5'h18, 5'h11, 5'h07, 5'h19, 5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    wr(A_CTRL_A, 32'h1);
    wr(A_BYTE_COUNT, 32'h2);
    foreach (q[i]) wr(A_QUEUE_BASE + 12'(4 * i), {24'h0, q[i]});
    wr(A_CTRL_B, 32'h1);
    wait_go();
    chk(32'(sink.got.size()), 32'd29);
    foreach (e[i]) chk({27'h0, sink.got[i]}, {27'h0, e[i]});
    chk({27'h0, sink.got[28]}, {27'h0, SYM_EOP});
    rd(A_SW_ABORT);
    chk(d, 32'h8);
    wr(A_SW_ABORT, 32'hf);
    $display("raw test done");
  endtask : t_raw
  task t_busy;
    line_idle <= 1'b0;
    wr(A_CTRL_A, 32'h0);
    wr(A_CTRL_B, 32'h1);
    wait_go();
    rd(A_SW_ABORT);
    chk(d, 32'h4);
    chk({31'h0, sw_abort_flag}, 32'h1);
    rd(A_AUTO_ABORT);
    chk(d, 32'h0);
    wr(A_SW_ABORT, 32'hf);
    $display("busy test done");
  endtask : t_busy
  // Busy line kept; a ping must not abort, a matching packet must
  task t_hold;
    wr(A_CTRL_A, 32'h4);
    wr(A_CTRL_B, 32'h1);
    repeat (150) @(posedge aclk);
    rx_ping_or_ack <= 1'b1;
    rx_good <= 1'b1;
    @(posedge aclk);
    rx_good <= 1'b0;
    rd(A_CTRL_B);
    chk({31'h0, d[CB_GO]}, 32'h1);
    rx_ping_or_ack <= 1'b0;
    rx_good <= 1'b1;
    @(posedge aclk);
    rx_good <= 1'b0;
    wait_go();
    rd(A_SW_ABORT);
    chk(d, 32'h2);
    wr(A_SW_ABORT, 32'hf);
    line_idle <= 1'b1;
    $display("hold test done");
  endtask : t_hold
  task t_abort;
    wr(A_CTRL_A, 32'h0);
    wr(A_CTRL_B, 32'h81);
    rx_hard_reset <= 1'b1;
    @(posedge aclk);
    rx_hard_reset <= 1'b0;
    wr(A_CTRL_B, 32'h4);
    wait_go();
    rd(A_SW_ABORT);
    chk(d, 32'h1);
    wr(12'h020, 32'h1);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("abort test done");
  endtask : t_abort
  // Raw frame with no stop code only ends at reset
  task t_wrap;
    int n0;
    wr(A_CTRL_A, 32'h3);
    wr(A_CTRL_B, 32'h2);
    repeat (75) wr(A_QUEUE_BASE, 32'h38);
    rd(A_QUEUE_BASE);
    chk(d, 32'h0);
    n0 = sink.got.size();
    wr(A_CTRL_B, 32'h1);
    repeat (400) @(posedge aclk);
    chk({31'h0, sink.got.size() - n0 > 74}, 32'h1);
    chk({27'h0, sink.got[$]}, {27'h0, SYM_SYNC1});
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_CTRL_A);
    chk(d, 32'h0);
    $display("wrap test done");
  endtask : t_wrap
  task t_own;
    int n0;
    wr(A_CTRL_A, 32'h1);
    wr(A_QUEUE_BASE, 32'h05);
    wr(A_QUEUE_BASE + 12'h004, 32'h2d);
    wr(A_QUEUE_BASE + 12'h008, 32'hfe);
    n0 = sink.got.size();
    wr(A_CTRL_B, 32'h1);
    wait_go();
    chk(32'(sink.got.size() - n0), 32'd2);
    chk({27'h0, sink.got[n0]}, 32'h0b);
    chk({27'h0, sink.got[n0 + 1]}, {27'h0, SYM_EOP});
    $display("own crc test done");
  endtask : t_own
  task t_auto;
    int n0;
    logic [4:0] e[8] = '{5'h18, 5'h18, 5'h18, 5'h11, 5'h09, 5'h14, 5'h15, 5'h0a};
    wr(A_CTRL_A, 32'h0);
    wr(A_QUEUE_BASE, 32'h21);
    wr(A_QUEUE_BASE + 12'h004, 32'h43);
    wr(A_BYTE_COUNT, 32'h2);
    rd(A_CTRL_B);
    chk({31'h0, d[CB_PERMIT]}, 32'h1);
    n0 = sink.got.size();
    wr(A_CTRL_B, 32'h1);
    do @(posedge aclk); while (frame_start !== 1'b1);
    chk({31'h0, analog_pwr_en}, 32'h1);
    wait_go();
    chk(32'(sink.got.size() - n0), 32'd17);
    foreach (e[i]) chk({27'h0, sink.got[n0 + i]}, {27'h0, e[i]});
    chk({27'h0, sink.got[n0 + 16]}, {27'h0, SYM_EOP});
    $display("auto test done");
  endtask : t_auto
  task t_rsp;
    req_ack <= 1'b1;
    @(posedge aclk);
    req_ack <= 1'b0;
    do @(posedge aclk); while (auto_start !== 1'b1);
    chk({31'h0, analog_pwr_en}, 32'h1);
    auto_done <= 1'b1;
    @(posedge aclk);
    auto_done <= 1'b0;
    rd(A_AUTO_ABORT);
    chk(d, 32'h8);
    $display("response test done");
  endtask : t_rsp
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    #100us;
    errors++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_raw();
    t_busy();
    t_hold();
    t_abort();
    t_wrap();
    t_own();
    t_auto();
    t_rsp();
    finish_test();
  end
endmodule : tb
